// *** include/bridge_cfg_consts.vh ***
// Purpose: Offsets, field positions, fixed read values and divider counts for the bridge config bank.
// Assumes: Byte addresses on an 8-bit APB address, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef BRIDGE_CFG_CONSTS_VH
`define BRIDGE_CFG_CONSTS_VH
`define OFS_EEPROM        8'h70
`define OFS_HOTSWAP       8'h74
`define OFS_BRIDGE_GPIO   8'h78
`define OFS_SEC_IRQ       8'h7C
`define OFS_PCIX_CAP      8'h80
`define EE_START_BIT      0
`define EE_DIR_BIT        1
`define EE_CLKSEL_LO      4
`define EE_AL_DIS_BIT     6
`define EE_FAST_BIT       7
`define HS_CAP_ID_ON      8'h06
`define HS_CAP_ID_OFF     8'h00
`define HS_NEXT_PTR       8'h00
`define HS_PROG_IF        2'h1
`define HS_HIDE_BIT       16
`define HS_MASK_BIT       17
`define HS_LED_BIT        19
`define HS_EXTRACT_BIT    22
`define HS_INSERT_BIT     23
`define BR_SERR_BIT       2
`define BR_SECRST_BIT     3
`define BR_VGA_LO         4
`define BR_VGA16_BIT      6
`define BR_MABORT_BIT     7
`define BR_PTMO_BIT       8
`define BR_STMO_BIT       9
`define BR_TMOSTAT_BIT    10
`define BR_TMOERR_BIT     11
`define GP_OCLR_LO        12
`define GP_OSET_LO        16
`define GP_ECLR_LO        20
`define GP_ESET_LO        24
`define PCIX_CAP_ID       8'h07
`define PCIX_NEXT_PTR     8'h90
`define SEC_IRQ_PIN_FWD   8'h01
`define EE_DIV_00         12'hFFF
`define EE_DIV_01         12'h7FF
`define EE_DIV_10         12'h3FF
`define EE_DIV_11         12'h07F
`define EE_FAST_SHIFT     5
`endif

// *** logic/bridge_cfg_regs.v ***
// Purpose: Device configuration bank 70h..83h of a PCIe to PCI/PCI-X bridge, reached over APB.
// Assumes: An external serial EEPROM engine on pclk; pins and straps pass two flip-flops first.
// Notes:   Zero-wait APB slave; read data is captured in the setup cycle.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
`include "bridge_cfg_consts.vh"
module bridge_cfg_regs (
  input  wire        pclk,                // APB clock, 25 MHz.
  input  wire        presetn,             // Asynchronous reset, active low.
  input  wire        psel,                // APB select.
  input  wire        penable,             // APB access phase.
  input  wire        pwrite,              // APB direction, high for write.
  input  wire [7:0]  paddr,               // APB byte address.
  input  wire [31:0] pwdata,              // APB write data.
  output wire        pready,              // Always ready, no wait states.
  output wire        pslverr,             // Error on unmapped address.
  output reg  [31:0] prdata,              // Read data.
  output reg         ee_start,            // One-cycle pulse launching an EEPROM access.
  output reg         ee_write,            // Access kind, high for write.
  output reg  [6:0]  ee_word_addr,        // EEPROM word address.
  output reg  [15:0] ee_wdata,            // EEPROM write data.
  output reg         ee_tick,             // One-cycle pulse per EEPROM clock step.
  input  wire        ee_done,             // Engine finished the access, pulse.
  input  wire        ee_nack,             // Acknowledge missed, valid with ee_done.
  output reg         al_start,            // One-cycle pulse launching the autoload.
  input  wire        al_done,             // Autoload finished, pulse.
  input  wire        al_ok,               // Autoload succeeded, valid with al_done.
  input  wire        hot_swap_enable_pin, // Hot swap enable pin.
  input  wire        insert_event,        // Insertion event pin, level.
  input  wire        extract_event,       // Extraction event pin, level.
  output reg         enum_req_n,          // Enumeration request, active low.
  output reg         hide_armed,          // Device hiding armed.
  output reg         led_on,              // Hot swap LED.
  input  wire        reverse_mode,        // Strap, high for reverse bridge.
  input  wire        pcix_mode,           // High while the bus runs PCI-X.
  output reg         serr_fwd_en,         // Forward SERR_L as error messages.
  output reg         sec_bus_reset,       // Hold secondary bus reset (forward mode).
  output reg         link_hot_reset,      // Hot reset on the link (reverse mode).
  output reg  [1:0]  vga_mode,            // VGA forwarding select.
  output reg         vga_decode16,        // VGA I/O decode 16 bits.
  output reg         mabort_report,       // Report master aborts.
  output reg         prim_discard_short,  // Primary discard timer 2^10.
  output reg         sec_discard_short,   // Secondary discard timer 2^10.
  input  wire        discard_expired,     // Discard timer expired, pulse.
  output reg         discard_err_req,     // Error report for an expiry, pulse.
  input  wire [3:0]  gpio_in,             // GPIO pin inputs.
  output reg  [3:0]  gpio_out,            // GPIO output values.
  output reg  [3:0]  gpio_oe              // GPIO output enables, high drives.
);
  localparam AL_IDLE = 2'h0;
  localparam AL_WAIT = 2'h1;
  localparam AL_BUSY = 2'h2;
  localparam AL_END  = 2'h3;

  reg  [31:16] ee_hi;
  reg  [1:0]   ee_clksel;
  reg          ee_go, ee_err, ee_al_dis, ee_fast, al_complete;
  reg  [1:0]   al_state;
  reg  [11:0]  div_cnt;
  reg          insertion_flag, extraction_flag, enum_mask;
  reg          serr_bit, secrst_bit, vga16_bit, mabort_bit, ptmo_bit, stmo_bit, tmo_stat, tmo_err_en;
  reg  [1:0]   vga_bits;
  reg  [7:0]   sec_irq_line;
  reg  [1:0]   rev_s, pcix_s, hs_s, insert_s, extract_s;
  reg  [3:0]   gpi_s1, gpi_s2;
  reg  [11:0]  next_div_max;
  reg  [31:0]  next_rdata;
  wire         rev, pcix, hs_enabled, pending;
  wire         setup, wr, mapped;
  wire [5:0]   widx;

  assign rev        = rev_s[1];
  assign pcix       = pcix_s[1];
  assign hs_enabled = hs_s[1];

  // Two flip-flop synchronisers; only the second stage is read by logic.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rev_s  <= 2'h0;
      pcix_s <= 2'h0;
      hs_s   <= 2'h0;
      insert_s  <= 2'h0;
      extract_s <= 2'h0;
      gpi_s1 <= 4'h0;
      gpi_s2 <= 4'h0;
    end else begin
      rev_s  <= {rev_s[0], reverse_mode};
      pcix_s <= {pcix_s[0], pcix_mode};
      hs_s   <= {hs_s[0], hot_swap_enable_pin};
      insert_s  <= {insert_s[0], insert_event};
      extract_s <= {extract_s[0], extract_event};
      gpi_s1 <= gpio_in;
      gpi_s2 <= gpi_s1;
    end
  end

  // APB decode; writes land on the access phase, reads are captured at setup.
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite;
  assign widx    = paddr[7:2];
  assign mapped  = ({widx, 2'b00} >= `OFS_EEPROM) && ({widx, 2'b00} <= `OFS_PCIX_CAP); // Whole words only.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign pending = insertion_flag | extraction_flag;

  // Read multiplexer; reserved and unmapped bits read as zero.
  always @* begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      `OFS_EEPROM:
        next_rdata = {ee_hi, ee_word_addr, (al_state == AL_BUSY), ee_fast, ee_al_dis, ee_clksel,
                      al_complete, ee_err, ee_write, ee_go};
      `OFS_HOTSWAP:
        next_rdata = {8'h00, insertion_flag, extraction_flag, `HS_PROG_IF, led_on, pending, enum_mask,
                      hide_armed, `HS_NEXT_PTR, (hs_enabled ? `HS_CAP_ID_ON : `HS_CAP_ID_OFF)};
      `OFS_BRIDGE_GPIO:
        next_rdata = {gpi_s2, 16'h0000, tmo_err_en, tmo_stat, stmo_bit, ptmo_bit, mabort_bit,
                      vga16_bit, vga_bits, secrst_bit, serr_bit, 2'h0};
      `OFS_SEC_IRQ:
        next_rdata = {16'h0000, (rev ? 8'h00 : `SEC_IRQ_PIN_FWD), sec_irq_line};
      `OFS_PCIX_CAP:
        next_rdata = {16'h0000, `PCIX_NEXT_PTR, `PCIX_CAP_ID};
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= next_rdata;
  end

  // EEPROM control word. A start is only honoured on a 0-to-1 change, so a
  // second write of 1 during a running access cannot relaunch the engine.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_go        <= 1'b0;
      ee_write     <= 1'b0;
      ee_err       <= 1'b0;
      ee_clksel    <= 2'h0;
      ee_al_dis    <= 1'b0;
      ee_fast      <= 1'b0;
      ee_hi        <= 16'h0000;
      ee_start     <= 1'b0;
      ee_word_addr <= 7'h00;
      ee_wdata     <= 16'h0000;
    end else begin
      ee_start <= 1'b0;
      if (ee_done && ee_go) begin
        ee_go  <= 1'b0;
        ee_err <= ee_nack;
      end
      if (wr && paddr == `OFS_EEPROM) begin
        ee_write     <= pwdata[`EE_DIR_BIT];
        ee_clksel    <= pwdata[`EE_CLKSEL_LO+1:`EE_CLKSEL_LO];
        ee_al_dis    <= pwdata[`EE_AL_DIS_BIT];
        ee_fast      <= pwdata[`EE_FAST_BIT];
        ee_hi        <= pwdata[31:16];
        ee_word_addr <= pwdata[15:9];
        ee_wdata     <= pwdata[31:16];
        if (pwdata[`EE_START_BIT] && !ee_go) begin
          ee_go    <= 1'b1;
          ee_start <= 1'b1;
        end
      end
    end
  end

  // Autoload sequencer: one load after reset unless software suppresses it
  // within the first cycle; the engine reports completion and success.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      al_state    <= AL_IDLE;
      al_start    <= 1'b0;
      al_complete <= 1'b0;
    end else begin
      al_start <= 1'b0;
      case (al_state)
        AL_IDLE: begin
          al_state <= AL_WAIT;
        end
        AL_WAIT: begin
          if (ee_al_dis) begin
            al_state <= AL_END;
          end else begin
            al_state <= AL_BUSY;
            al_start <= 1'b1;
          end
        end
        AL_BUSY: begin
          if (al_done) begin
            al_state    <= AL_END;
            al_complete <= al_ok;
          end
        end
        AL_END: begin
          al_state <= AL_END;
        end
        default: begin
          al_state <= AL_END;
        end
      endcase
    end
  end

  // EEPROM clock divider. The fast option only shortens the autoload period.
  always @* begin
    case (ee_clksel)
      2'h0:    next_div_max = `EE_DIV_00;
      2'h1:    next_div_max = `EE_DIV_01;
      2'h2:    next_div_max = `EE_DIV_10;
      default: next_div_max = `EE_DIV_11;
    endcase
    if (ee_fast && al_state == AL_BUSY)
      next_div_max = next_div_max >> `EE_FAST_SHIFT;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 12'h000;
      ee_tick <= 1'b0;
    end else if (div_cnt >= next_div_max) begin
      div_cnt <= 12'h000;
      ee_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 12'h001;
      ee_tick <= 1'b0;
    end
  end

  // Hot swap control. An event that arrives with a clearing write wins.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hide_armed <= 1'b0;
      enum_mask  <= 1'b0;
      led_on     <= 1'b0;
      insertion_flag  <= 1'b1;
      extraction_flag <= 1'b0;
    end else begin
      if (wr && paddr == `OFS_HOTSWAP) begin
        hide_armed <= pwdata[`HS_HIDE_BIT];
        enum_mask  <= pwdata[`HS_MASK_BIT];
        led_on     <= pwdata[`HS_LED_BIT];
      end
      if (insert_s[1])
        insertion_flag <= 1'b1;
      else if (wr && paddr == `OFS_HOTSWAP && pwdata[`HS_INSERT_BIT])
        insertion_flag <= 1'b0;
      if (extract_s[1])
        extraction_flag <= 1'b1;
      else if (wr && paddr == `OFS_HOTSWAP && pwdata[`HS_EXTRACT_BIT])
        extraction_flag <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      enum_req_n <= 1'b1;
    else
      enum_req_n <= ~(pending & ~enum_mask);
  end

  // Bridge control and GPIO share one word; serr_bit, ptmo_bit and stmo_bit refuse writes outside their own direction.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serr_bit     <= 1'b0;
      secrst_bit   <= 1'b0;
      vga_bits     <= 2'h0;
      vga16_bit    <= 1'b0;
      mabort_bit   <= 1'b0;
      ptmo_bit     <= 1'b0;
      stmo_bit     <= 1'b0;
      tmo_stat     <= 1'b0;
      tmo_err_en   <= 1'b0;
      sec_irq_line <= 8'h00;
    end else begin
      if (wr && paddr == `OFS_BRIDGE_GPIO) begin
        if (!rev)
          serr_bit <= pwdata[`BR_SERR_BIT];
        secrst_bit <= pwdata[`BR_SECRST_BIT];
        vga_bits   <= pwdata[`BR_VGA_LO+1:`BR_VGA_LO];
        vga16_bit  <= pwdata[`BR_VGA16_BIT];
        mabort_bit <= pwdata[`BR_MABORT_BIT];
        if (rev)
          ptmo_bit <= pwdata[`BR_PTMO_BIT];
        if (!rev)
          stmo_bit <= pwdata[`BR_STMO_BIT];
        tmo_err_en <= pwdata[`BR_TMOERR_BIT];
      end
      if (discard_expired)
        tmo_stat <= 1'b1;
      else if (wr && paddr == `OFS_BRIDGE_GPIO && pwdata[`BR_TMOSTAT_BIT])
        tmo_stat <= 1'b0;
      if (wr && paddr == `OFS_SEC_IRQ)
        sec_irq_line <= pwdata[7:0];
    end
  end

  // GPIO per-bit set and clear; set wins when both are written at once.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gpio_bit
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gpio_out[g] <= 1'b0;
          gpio_oe[g]  <= 1'b0;
        end else if (wr && paddr == `OFS_BRIDGE_GPIO) begin
          if (pwdata[`GP_OSET_LO+g])
            gpio_out[g] <= 1'b1;
          else if (pwdata[`GP_OCLR_LO+g])
            gpio_out[g] <= 1'b0;
          if (pwdata[`GP_ESET_LO+g])
            gpio_oe[g] <= 1'b1;
          else if (pwdata[`GP_ECLR_LO+g])
            gpio_oe[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Registered control outputs; SERR, reset and discard timer outputs qualified by bridge direction, the error report by bus mode.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serr_fwd_en        <= 1'b0;
      sec_bus_reset      <= 1'b0;
      link_hot_reset     <= 1'b0;
      vga_mode           <= 2'h0;
      vga_decode16       <= 1'b0;
      mabort_report      <= 1'b0;
      prim_discard_short <= 1'b0;
      sec_discard_short  <= 1'b0;
      discard_err_req    <= 1'b0;
    end else begin
      serr_fwd_en        <= serr_bit & ~rev;
      sec_bus_reset      <= secrst_bit & ~rev;
      link_hot_reset     <= secrst_bit & rev;
      vga_mode           <= vga_bits;
      vga_decode16       <= vga16_bit;
      mabort_report      <= mabort_bit;
      prim_discard_short <= ptmo_bit & rev;
      sec_discard_short  <= stmo_bit & ~rev;
      discard_err_req    <= discard_expired & tmo_err_en & ~pcix;
    end
  end
endmodule // bridge_cfg_regs

// *** bench/bridge_cfg_regs_checker.sv ***
// Purpose: Port-level timing checks for the bridge config bank.
// Assumes: Zero-wait APB slave, one clock domain.
// Notes:   Bound to every instance of the bank.
`timescale 1ns/100ps
module bridge_cfg_regs_checker (
  input wire        pclk,            // Clock.
  input wire        presetn,         // Reset, active low.
  input wire        psel,            // APB select.
  input wire        penable,         // APB access phase.
  input wire        pwrite,          // APB direction.
  input wire [7:0]  paddr,           // APB address.
  input wire [31:0] pwdata,          // APB write data.
  input wire        pready,          // APB ready.
  input wire        pslverr,         // APB error.
  input wire [31:0] prdata,          // APB read data.
  input wire        ee_start,        // EEPROM launch.
  input wire        ee_write,        // EEPROM direction.
  input wire [6:0]  ee_word_addr,    // EEPROM word address.
  input wire [15:0] ee_wdata,        // EEPROM write data.
  input wire        ee_tick,         // EEPROM clock step.
  input wire        al_start,        // Autoload launch.
  input wire        discard_expired, // Discard expiry.
  input wire        discard_err_req, // Discard error report.
  input wire        sec_bus_reset,   // Secondary reset.
  input wire        link_hot_reset   // Link hot reset.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Launch cause and the fields it must carry, kept as plain wires for $past.
  wire        ee_go     = psel && penable && pwrite && paddr == 8'h70 && pwdata[0];
  wire [23:0] ee_fields = {pwdata[31:9], pwdata[1]};
  sequence rd_setup_s;
    psel && !penable && !pwrite;
  endsequence
  sequence rd_access_s;
    psel && penable;
  endsequence
  pready_high_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (psel && penable |->
    pslverr == (paddr[7:2] < 6'h1C || paddr[7:2] > 6'h20)) else $error("pslverr wrong");
  read_hold_a: assert property (rd_setup_s ##1 rd_access_s |=> $stable(prdata)) else $error("prdata moved");
  ee_launch_a: assert property (ee_start |-> $past(ee_go)) else $error("ee_start without cause");
  ee_fields_a: assert property (ee_start |->
    {ee_wdata, ee_word_addr, ee_write} == $past(ee_fields)) else $error("EEPROM fields wrong");
  ee_pulse_a: assert property (ee_start |=> !ee_start) else $error("ee_start too long");
  tick_gap_a: assert property (ee_tick |=> !ee_tick [*3]) else $error("ee_tick too close");
  discard_err_a: assert property (discard_err_req |-> $past(discard_expired)) else $error("stray report");
  reset_side_a: assert property (!(sec_bus_reset && link_hot_reset)) else $error("both resets");
  autoload_once_a: assert property (al_start |=> !al_start [*8]) else $error("autoload relaunched");
endmodule // bridge_cfg_regs_checker
bind bridge_cfg_regs bridge_cfg_regs_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .prdata, .ee_start, .ee_write, .ee_word_addr, .ee_wdata, .ee_tick, .al_start,
  .discard_expired, .discard_err_req, .sec_bus_reset, .link_hot_reset);

// *** bench/tb_bridge_cfg_regs.sv ***
// Purpose: Self-checking bench for the bridge config bank.
// Assumes: Zero-wait APB slave; pins pass two sync flops.
// Notes:   Seeded random data with fixed corner cases.
`timescale 1ns/100ps
module tb_bridge_cfg_regs;
  logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic        ee_done = 1'b0, ee_nack = 1'b0, al_done = 1'b0, al_ok = 1'b0, hot_swap_enable_pin = 1'b1;
  logic        insert_event = 1'b0, extract_event = 1'b0, reverse_mode = 1'b0, pcix_mode = 1'b0;
  logic        discard_expired = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q, v, r;
  logic [3:0]  gpio_in = 4'h0;
  wire         pready, pslverr, ee_start, ee_write, ee_tick, al_start, enum_req_n, hide_armed, led_on;
  wire         serr_fwd_en, sec_bus_reset, link_hot_reset, vga_decode16, mabort_report, discard_err_req;
  wire         prim_discard_short, sec_discard_short;
  wire [31:0]  prdata;
  wire [6:0]   ee_word_addr;
  wire [15:0]  ee_wdata;
  wire [1:0]   vga_mode;
  wire [3:0]   gpio_out, gpio_oe;
  int          fail_count = 0, compares = 0, n, k;
  wire [8:0]   outs = {serr_fwd_en, sec_bus_reset, link_hot_reset, vga_mode, vga_decode16, mabort_report,
                       prim_discard_short, sec_discard_short};
  bridge_cfg_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .ee_start, .ee_write, .ee_word_addr, .ee_wdata, .ee_tick, .ee_done, .ee_nack, .al_start, .al_done, .al_ok,
    .hot_swap_enable_pin, .insert_event, .extract_event, .enum_req_n, .hide_armed, .led_on, .reverse_mode, .pcix_mode,
    .serr_fwd_en, .sec_bus_reset, .link_hot_reset, .vga_mode, .vga_decode16, .mabort_report, .prim_discard_short,
    .sec_discard_short, .discard_expired, .discard_err_req, .gpio_in, .gpio_out, .gpio_oe);
  // Free-running 25 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic tk(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chkb(input string nm, input logic exp, input logic got);
    chk(nm, {31'h0, exp}, {31'h0, got});
  endtask
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n == 20) fail_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] hs_exp(input logic pin, inserted, extracted, input logic [1:0] hm);
    return {8'h0, inserted, extracted, 2'b01, 1'b0, inserted | extracted, hm, 8'h00, pin ? 8'h06 : 8'h00};
  endfunction
  function automatic logic [31:0] ee_exp(input logic [31:0] w, input logic err);
    return {w[31:9], 1'b0, w[7:4], 1'b1, err, w[1], 1'b1};
  endfunction
  // Ignored timer and forwarding bits read back 0 because writes to them are refused outside the mode that owns them.
  function automatic logic [31:0] br_exp(input logic [31:0] w, input logic rv);
    return {20'h0, w[11], 1'b0, w[9] & ~rv, w[8] & rv, w[7:3], w[2] & ~rv, 2'b00};
  endfunction
  function automatic logic [8:0] out_exp(input logic [31:0] w, input logic rv);
    return {w[2] & ~rv, w[3] & ~rv, w[3] & rv, w[5:4], w[6], w[7], w[8] & rv, w[9] & ~rv};
  endfunction
  function automatic int div_exp(input int c);
    return c == 0 ? 4096 : c == 1 ? 2048 : c == 2 ? 1024 : 128;
  endfunction
  task results;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog sized well above the longest divider measurements.
  initial begin
    tk(60000);
    fail_count++;
    results;
  end
  // Main sequence.
  initial begin
    r = $urandom(11260);
    tk(5);
    presetn <= 1'b1;
    for (n = 0; n < 10 && al_start !== 1'b1; n++) tk(1);
    chkb("al_start", 1'b1, al_start);
    apb(0, 8'h70, 0);
    chk("autoload busy", 32'h100, q);
    // Fast autoload must cut the slowest divider by 32 while the load still runs.
    apb(1, 8'h70, 32'h80);
    for (n = 0; n < 5000 && ee_tick !== 1'b1; n++) tk(1);
    tk(1);
    for (n = 1; n < 5000 && ee_tick !== 1'b1; n++) tk(1);
    chk("fast tick period", div_exp(0) / 32, n);
    al_ok <= 1'b1;
    al_done <= 1'b1;
    tk(1);
    al_done <= 1'b0;
    apb(0, 8'h70, 0);
    chk("autoload done", 32'h088, q);
    apb(0, 8'h74, 0);
    chk("hs reset", hs_exp(1, 1, 0, 2'b00), q);
    chkb("enum insert", 1'b0, enum_req_n);
    apb(1, 8'h74, 32'hFFB0_FFFF);
    apb(0, 8'h74, 0);
    chk("hs insert clear", hs_exp(1, 0, 0, 2'b00), q);
    chkb("enum idle", 1'b1, enum_req_n);
    extract_event <= 1'b1;
    tk(5);
    apb(0, 8'h74, 0);
    chk("hs extract", hs_exp(1, 0, 1, 2'b00), q);
    chkb("enum extract", 1'b0, enum_req_n);
    apb(1, 8'h74, 32'h000B_0000);
    tk(2);
    chk("hide mask", 32'h7, {29'h0, led_on, hide_armed, enum_req_n});
    extract_event <= 1'b0;
    tk(4);
    apb(1, 8'h74, 32'h0043_0000);
    apb(0, 8'h74, 0);
    chk("hs extract clear", hs_exp(1, 0, 0, 2'b11), q);
    for (k = 0; k < 4; k++) begin
      v = $urandom;
      v[8:0] = {3'b000, 2'(k), 2'b00, v[1], 1'b1};
      apb(1, 8'h70, v);
      for (n = 0; n < 4 && ee_start !== 1'b1; n++) tk(1);
      chk("ee launch", {v[31:9], v[1], 8'h01}, {ee_wdata, ee_word_addr, ee_write, 7'h0, ee_start});
      for (n = 0; n < 5000 && ee_tick !== 1'b1; n++) tk(1);
      tk(1);
      for (n = 1; n < 5000 && ee_tick !== 1'b1; n++) tk(1);
      chk("tick period", div_exp(k), n);
      apb(0, 8'h70, 0);
      chk("ee busy", ee_exp(v, k > 0 && k[0] == 1'b0), q);
      ee_nack <= k[0];
      ee_done <= 1'b1;
      tk(1);
      ee_done <= 1'b0;
      apb(0, 8'h70, 0);
      chk("ee done", ee_exp(v, k[0]) & 32'hFFFF_FFFE, q);
    end
    for (k = 0; k < 6; k++) begin
      v = $urandom & 32'h0000_0FFF;
      v[5:4] = 2'(k % 3);
      apb(1, 8'h78, v);
      apb(0, 8'h78, 0);
      chk("bridge ctrl", br_exp(v, 0), q & 32'hFFF);
      chk("bridge outs", {23'h0, out_exp(v, 0)}, {23'h0, outs});
    end
    apb(1, 8'h78, 32'h800);
    for (k = 0; k < 2; k++) begin
      pcix_mode <= k[0];
      tk(4);
      discard_expired <= 1'b1;
      tk(1);
      discard_expired <= 1'b0;
      n = 0;
      repeat (4) begin
        tk(1);
        n += int'(discard_err_req === 1'b1);
      end
      chk("discard report", 32'(k == 0), n);
    end
    apb(0, 8'h78, 0);
    chk("discard status", 32'hC00, q & 32'hC00);
    apb(1, 8'h78, 32'hC00);
    apb(0, 8'h78, 0);
    chk("discard clear", 32'h800, q & 32'hC00);
    r = $urandom;
    gpio_in <= r[19:16];
    apb(1, 8'h78, {4'h0, r[3:0], 4'h0, r[7:4], 16'h0});
    apb(1, 8'h78, {8'h0, r[11:8], 4'h0, r[15:12], 12'h0});
    apb(0, 8'h78, 0);
    chk("gpio", {r[19:16], 20'h0, r[3:0] & ~r[11:8], r[7:4] & ~r[15:12]}, {q[31:28], 20'h0, gpio_oe, gpio_out});
    apb(1, 8'h7C, r);
    apb(0, 8'h7C, 0);
    chk("sec irq fwd", {16'h0, 8'h01, r[7:0]}, q);
    apb(1, 8'h80, r);
    apb(0, 8'h80, 0);
    chk("pcix cap", 32'h9007, q & 32'hFFFF);
    apb(0, 8'h84, 0);
    chk("unmapped data", 32'h0, q);
    chkb("unmapped err", 1'b1, e);
    apb(1, 8'h78, 0);
    reverse_mode <= 1'b1;
    tk(4);
    apb(1, 8'h78, 32'h30C);
    apb(0, 8'h78, 0);
    chk("bridge rev", br_exp(32'h30C, 1), q & 32'hFFF);
    chk("bridge rev outs", {23'h0, out_exp(32'h30C, 1)}, {23'h0, outs});
    hot_swap_enable_pin <= 1'b0;
    tk(4);
    apb(0, 8'h74, 0);
    chk("hs id off", 32'h0, q & 32'hFFFF);
    results;
  end
endmodule // tb_bridge_cfg_regs
